// >>> rtl/cmg_main_gate.sv
/*
 main gate, arming, resolution, status, lamp and processor start logic.
 assumes channel and reference edges as one-cycle synchronous pulses and an
 apb master on pclk; control bits live in a local register.
*/
`timescale 1ns/100ps
`default_nettype none
module cmg_main_gate
	import cmg_pkg::*;
#(
	parameter int LAMP_CYCLES = CMG_LAMP_CYCLES
)
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// signal inputs (pulses)
	input  wire logic        chan_a_pulse,
	input  wire logic        chan_b_pulse,
	input  wire logic        ref_pulse,
	input  wire logic        sample_rate_done,
	input  wire logic        time_digit_valid,
	input  wire logic [3:0]  time_digit,
	input  wire logic        input_stage_clear,
	// outputs
	output cmg_scale_s       scale_out,
	output logic             event_window_line,
	output logic             window_open_status,
	output logic             processing_kickoff_n,
	output logic             ref_shutoff,
	output logic             trigger_disable,
	output logic             arm_lamp,
	output logic             window_lamp_drive
);

	////////////////////////////////////////////////////////////////////////////
	// register file
	cmg_ctrl_s ctrl_q;
	wire logic setup_w  = psel && !penable;
	wire logic access_w = psel && penable;
	wire logic hit_ctrl = paddr == CMG_OFS_CTRL;
	wire logic hit_stat = paddr == CMG_OFS_STATUS;
	wire logic [31:0] stat_w;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_q <= cmg_ctrl_s'(CMG_CTRL_RESET[5:0]);
		end
		else if (access_w && pwrite && hit_ctrl)
		begin
			ctrl_q <= cmg_ctrl_s'(pwdata[5:0]);
		end

	// zero wait states: the answer stands in the access cycle only
	wire logic [31:0] rdata_w = !setup_w || pwrite ? 32'h0000_0000 :
		hit_ctrl ? {26'h000_0000, ctrl_q} : hit_stat ? stat_w : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready <= 1'b0;
		end
		else
		begin
			pready <= setup_w;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pslverr <= 1'b0;
		end
		else
		begin
			pslverr <= setup_w && !(hit_ctrl || hit_stat);
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
		end
		else
		begin
			prdata <= rdata_w;
		end

	////////////////////////////////////////////////////////////////////////////
	// mode decode and routing
	wire cmg_mode_e mode_w = cmg_decode(ctrl_q.ratio_or_totalize_select,
		ctrl_q.interval_or_events_select);
	wire logic totalize_w = mode_w == CMG_MODE_RATIO && ctrl_q.gate_internal == 1'b0;
	wire logic ratio_w    = mode_w == CMG_MODE_RATIO;
	wire logic interval_w = mode_w == CMG_MODE_INTERVAL;
	// ratio and totalize take channel B as the time clock
	wire logic tclk_w = ratio_w ? chan_b_pulse : ref_pulse;
	wire logic preset_w = totalize_w && ctrl_q.totalize_stop;

	////////////////////////////////////////////////////////////////////////////
	// arming sequence
	cmg_seq_e seq_q;
	logic     ready_q;
	logic     res_q;
	logic     in_win_q;
	logic     ref_win_q;
	logic     b_admit_q;
	logic     status_q;
	logic     kick_q;

	wire logic digit_end_w = ready_q && time_digit_valid && time_digit == CMG_DIGIT_END;
	wire logic arm_en_w = totalize_w ? !preset_w :
		ready_q && ctrl_q.gate_internal;
	wire logic open_w  = !in_win_q && arm_en_w && chan_a_pulse && !preset_w;
	wire logic close_a = in_win_q && !interval_w && !arm_en_w && chan_a_pulse;
	wire logic close_b = in_win_q && interval_w && b_admit_q && chan_b_pulse;
	wire logic close_w = close_a || close_b || (in_win_q && preset_w);
	wire logic status_fall = status_q && !(in_win_q || ref_win_q);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			seq_q <= CMG_SEQ_RUNDOWN;
		end
		else
		begin
			case (seq_q)
				CMG_SEQ_RUNDOWN:
				begin
					if (sample_rate_done)
						seq_q <= CMG_SEQ_MEASURE;
				end
				CMG_SEQ_MEASURE:
				begin
					if (status_fall)
						seq_q <= CMG_SEQ_PROCESS;
				end
				CMG_SEQ_PROCESS:
				begin
					if (input_stage_clear)
						seq_q <= CMG_SEQ_RUNDOWN;
				end
				default:
				begin
					seq_q <= CMG_SEQ_RUNDOWN;
				end
			endcase
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			res_q <= 1'b0;
		end
		else
		begin
			// the digit check is gated by readiness so scaler reads cannot retrigger
			res_q <= digit_end_w ? 1'b1 : (sample_rate_done ? 1'b0 : res_q);
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ready_q <= 1'b0;
		end
		else
		begin
			if (digit_end_w || (totalize_w && preset_w))
				ready_q <= 1'b0;
			else if (seq_q == CMG_SEQ_RUNDOWN && sample_rate_done)
				ready_q <= 1'b1;
		end

	////////////////////////////////////////////////////////////////////////////
	// window flip-flops (q high means open)
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			in_win_q <= 1'b0;
		end
		else
		begin
			if (open_w)
				in_win_q <= 1'b1;
			else if (close_w)
				in_win_q <= 1'b0;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			b_admit_q <= 1'b0;
		end
		else
		begin
			b_admit_q <= interval_w && (open_w || (in_win_q && !close_w));
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ref_win_q <= 1'b0;
		end
		else
		begin
			if (preset_w)
				ref_win_q <= 1'b0;
			else if (tclk_w)
				ref_win_q <= in_win_q;
		end

	////////////////////////////////////////////////////////////////////////////
	// prescalers: divide by two then by ten
	logic       ev_b_q;
	logic       tm_b_q;
	logic [3:0] ev_d_q;
	logic [3:0] tm_d_q;
	wire logic ev_in = in_win_q && (interval_w ? close_b : chan_a_pulse);
	wire logic tm_in = ref_win_q && tclk_w;
	wire logic ev_carry = ev_in && ev_b_q;
	wire logic tm_carry = tm_in && tm_b_q;

	function automatic logic [3:0] cmg_dec(input logic [3:0] d);
		return d == 4'(CMG_PRE_DIV10 - 1) ? 4'h0 : d + 4'h1;
	endfunction

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ev_b_q <= 1'b0;
		end
		else
		begin
			if (ev_in)
				ev_b_q <= !ev_b_q;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tm_b_q <= 1'b0;
		end
		else
		begin
			if (tm_in)
				tm_b_q <= !tm_b_q;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ev_d_q <= 4'h0;
		end
		else
		begin
			if (ev_carry)
				ev_d_q <= cmg_dec(ev_d_q);
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tm_d_q <= 4'h0;
		end
		else
		begin
			if (tm_carry)
				tm_d_q <= cmg_dec(tm_d_q);
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			scale_out <= '0;
		end
		else
		begin
			scale_out.event_div20 <= ev_carry && ev_d_q == 4'(CMG_PRE_DIV10 - 1);
			scale_out.time_div20  <= tm_carry && tm_d_q == 4'(CMG_PRE_DIV10 - 1);
		end

	////////////////////////////////////////////////////////////////////////////
	// status, lamps, processor start, turn-off control
	logic [31:0] lamp_cnt_q;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			status_q <= 1'b0;
		end
		else
		begin
			if (open_w)
				status_q <= 1'b1;
			else if (status_fall)
				status_q <= 1'b0;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			kick_q <= 1'b0;
		end
		else
		begin
			// set wins over the clear
			if (status_fall && !totalize_w)
				kick_q <= 1'b1;
			else if (input_stage_clear)
				kick_q <= 1'b0;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			lamp_cnt_q <= 32'h0000_0000;
		end
		else
		begin
			if (status_q)
				lamp_cnt_q <= 32'(LAMP_CYCLES);
			else if (lamp_cnt_q != 32'h0000_0000)
				lamp_cnt_q <= lamp_cnt_q - 32'h0000_0001;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			event_window_line    <= 1'b0;
			window_open_status   <= 1'b0;
			processing_kickoff_n <= 1'b1;
			arm_lamp             <= 1'b0;
		end
		else
		begin
			event_window_line    <= in_win_q;
			window_open_status   <= status_q;
			processing_kickoff_n <= !kick_q;
			arm_lamp             <= ready_q && !in_win_q;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			window_lamp_drive <= 1'b0;
		end
		else
		begin
			window_lamp_drive <= status_q || lamp_cnt_q != 32'h0000_0000;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ref_shutoff     <= 1'b0;
			trigger_disable <= 1'b0;
		end
		else
		begin
			ref_shutoff     <= ctrl_q.ratio_or_totalize_select || ctrl_q.plugin_c_select;
			trigger_disable <= ctrl_q.plugin_ab_select;
		end

	assign stat_w = {22'h00_0000, mode_w, seq_q, kick_q, status_q, ref_win_q,
		in_win_q, res_q, ready_q};

endmodule // cmg_main_gate
`default_nettype wire

// >>> rtl/cmg_pkg.sv
/*
 main gate and arming control package: constants, mode enums and carriers.
 assumes one 125 MHz clock; channel and reference edges arrive as
 one-cycle pulses already synchronous to that clock.
*/
// How it works
// - two select lines pick one of three modes
// - first input after arming opens input window
// - reference edge after input window opens time window
// - each path divides by two then ten
// - arm drop closes input window next input
// - time window closes next reference edge after
// - totalize routes channel B as reference, arm held
// - stop forces preset, clears windows, ends count
// - ratio: A events, B time, gate time governs
// - interval counts reference between A and B
// - interval: A opens, reference starts, B admitted
// - interval: B closes, counts one, reference stops
// - reference off when ratio or channel C selected
// - plug-in A/B select disables local triggers
// - cycle arm, measure, process, display repeats
// - arm request sets readiness, enables input window
// - arm lamp while armed, gate lamp when open
// - digit five while armed resets readiness
// - readiness reset forces arm enable false outside totalize
// - window status from input until reference closes
// - one-shot holds lamp forty ms after close
// - status fall sets kickoff, input clear resets; totalize never sets kickoff
package cmg_pkg;

	localparam int CMG_CLK_HZ      = 125_000_000;
	localparam int CMG_LAMP_MS     = 40;
	localparam int CMG_LAMP_CYCLES = CMG_CLK_HZ / 1000 * CMG_LAMP_MS;
	localparam int CMG_PRE_DIV2    = 2;
	localparam int CMG_PRE_DIV10   = 10;
	localparam logic [3:0] CMG_DIGIT_END = 4'h5;

	localparam logic [31:0] CMG_OFS_CTRL   = 32'h0000_0000;
	localparam logic [31:0] CMG_OFS_STATUS = 32'h0000_0004;
	localparam logic [31:0] CMG_CTRL_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		CMG_MODE_FREQ,
		CMG_MODE_RATIO,
		CMG_MODE_INTERVAL
	} cmg_mode_e;

	typedef enum logic [1:0] {
		CMG_SEQ_RUNDOWN,
		CMG_SEQ_MEASURE,
		CMG_SEQ_PROCESS
	} cmg_seq_e;

	typedef struct packed {
		logic ratio_or_totalize_select;
		logic interval_or_events_select;
		logic plugin_ab_select;
		logic plugin_c_select;
		logic totalize_stop;
		logic gate_internal;
	} cmg_ctrl_s;

	typedef struct packed {
		logic event_div20;
		logic time_div20;
	} cmg_scale_s;

	function automatic cmg_mode_e cmg_decode(input logic rt, input logic ie);
		if (rt && !ie)
			return CMG_MODE_RATIO;
		else if (!rt && ie)
			return CMG_MODE_INTERVAL;
		else
			return CMG_MODE_FREQ;
	endfunction

endpackage

// >>> test/cmg_far_end.sv
/*
 far end model: time scaler digit source and processor clear.
 assumes one pclk domain and the gate's one-cycle time_div20 pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module cmg_far_end
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// from the gate
	input  wire logic       time_div20,
	input  wire logic       processing_kickoff_n,
	// to the gate
	output logic            time_digit_valid,
	output logic [3:0]      time_digit,
	output logic            input_stage_clear
);
	int wait_q;
	assign time_digit_valid = 1'b1;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			time_digit <= 4'h0;
			wait_q <= 0;
			input_stage_clear <= 1'b0;
		end
		else
		begin
			input_stage_clear <= 1'b0;
			wait_q <= processing_kickoff_n ? 0 : wait_q + 1;
			if (time_div20)
				time_digit <= (time_digit == 4'h9) ? 4'h0 : time_digit + 4'h1;
			if (wait_q == 8)
			begin
				input_stage_clear <= 1'b1;
				time_digit <= 4'h0;
			end
		end
	end
endmodule // cmg_far_end
`default_nettype wire

// >>> test/cmg_main_gate_monitor.sv
/*
 checker on the main gate ports.
 assumes single pclk domain, bound into every cmg_main_gate.
*/
`timescale 1ns/100ps
`default_nettype none
module cmg_main_gate_monitor
	import cmg_pkg::*;
#(
	parameter int LAMP_CYCLES = 20
)
(
	// watched ports
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pready,
	input  wire logic       pslverr,
	input  wire logic       chan_a_pulse,
	input  wire logic       chan_b_pulse,
	input  wire logic       input_stage_clear,
	input  wire cmg_scale_s scale_out,
	input  wire logic       event_window_line,
	input  wire logic       window_open_status,
	input  wire logic       processing_kickoff_n,
	input  wire logic       arm_lamp,
	input  wire logic       window_lamp_drive
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_done; $fell(window_open_status); endsequence
	sequence s_open; $rose(event_window_line); endsequence
	a_apb_answer: assert property (s_setup |=> pready) else $error("no answer");
	a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
	a_open_on_a: assert property (s_open |-> $past(chan_a_pulse) || $past(chan_a_pulse, 2))
		else $error("open without a");
	a_close_on_edge: assert property ($fell(event_window_line) |->
		$past(chan_a_pulse) || $past(chan_a_pulse, 2) || $past(chan_b_pulse)
		|| $past(chan_b_pulse, 2)) else $error("close without edge");
	a_status_open: assert property ($rose(window_open_status) |-> ##[0:1] event_window_line)
		else $error("status without window");
	a_status_close: assert property (s_done |-> !event_window_line)
		else $error("status fell early");
	a_kick_after: assert property (s_done |-> ##[1:3] !processing_kickoff_n)
		else $error("no kickoff");
	a_lamp_swap: assert property (s_open |-> ##[0:2] (window_lamp_drive && !arm_lamp))
		else $error("lamps not swapped");
	a_div_pulse: assert property (scale_out.time_div20 |=> !scale_out.time_div20)
		else $error("long divide pulse");
	a_clear_kick: assert property (input_stage_clear && !processing_kickoff_n
		&& !window_open_status |-> ##[1:2] processing_kickoff_n)
		else $error("kickoff stuck");
endmodule // cmg_main_gate_monitor
bind cmg_main_gate cmg_main_gate_monitor #(.LAMP_CYCLES(LAMP_CYCLES)) u_mon (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .chan_a_pulse(chan_a_pulse), .chan_b_pulse(chan_b_pulse),
	.input_stage_clear(input_stage_clear), .scale_out(scale_out),
	.event_window_line(event_window_line), .window_open_status(window_open_status),
	.processing_kickoff_n(processing_kickoff_n), .arm_lamp(arm_lamp),
	.window_lamp_drive(window_lamp_drive));
`default_nettype wire

// >>> test/cmg_main_gate_test.sv
/*
 self-checking bench for cmg_main_gate over apb.
 assumes cmg_far_end answers digits and the processor clear.
*/
`timescale 1ns/100ps
`default_nettype none
module cmg_main_gate_test
	import cmg_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd, x, v;
	logic pready, pslverr, er, tdv, icl, ewl, wos, kn, rso, tdis, al, wl;
	logic a = 0, b = 0, r = 0, srd = 0;
	logic [3:0] td;
	cmg_scale_s so;
	int err_total = 0, num_checks = 0, seed = 45, i, n;
	always #4 pclk = ~pclk;
	cmg_main_gate #(.LAMP_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chan_a_pulse(a), .chan_b_pulse(b),
		.ref_pulse(r), .sample_rate_done(srd), .time_digit_valid(tdv), .time_digit(td),
		.input_stage_clear(icl), .scale_out(so), .event_window_line(ewl),
		.window_open_status(wos), .processing_kickoff_n(kn), .ref_shutoff(rso),
		.trigger_disable(tdis), .arm_lamp(al), .window_lamp_drive(wl));
	cmg_far_end i_far (.pclk(pclk), .presetn(presetn), .time_div20(so.time_div20),
		.processing_kickoff_n(kn), .time_digit_valid(tdv), .time_digit(td),
		.input_stage_clear(icl));
	////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [31:0] ad, d);
		@(posedge pclk);
		psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d; penable <= 0;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata; er = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic cyc(input logic pa, pb, pr);
		@(posedge pclk);
		a <= pa; b <= pb; r <= pr;
	endtask
	task automatic arm;
		@(posedge pclk); srd <= 1;
		@(posedge pclk); srd <= 0;
		repeat (3) @(posedge pclk);
	endtask
	function automatic logic [1:0] exp_mode(input logic rt, ie);
		return (rt && !ie) ? 2'h1 : ((!rt && ie) ? 2'h2 : 2'h0);
	endfunction
	task close_out;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		close_out();
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		chk("kick_rst", 1, kn);
		apb(0, 32'h0000_0008, 0);
		chk("slverr", 1, er);
		chk("unmapped", 0, rd);
		for (i = 0; i < 4; i++)
		begin
			x = $random(seed);
			v = {26'h0, i[1:0], x[3:2], 2'b00};
			apb(1, CMG_OFS_CTRL, v);
			apb(0, CMG_OFS_CTRL, 0);
			chk("ctrl", v, rd);
			apb(0, CMG_OFS_STATUS, 0);
			chk("mode", exp_mode(v[5], v[4]), rd[9:8]);
			chk("ref_off", v[5] | v[2], rso);
			chk("trig_off", v[3], tdis);
		end
		apb(1, CMG_OFS_CTRL, 32'h0000_0001);
		arm();
		chk("arm_lamp", 1, al);
		n = 0;
		while (kn !== 1'b0 && n < 5000)
		begin
			x = $random(seed);
			cyc(x[0] & x[1], 0, x[2]);
			n++;
		end
		chk("kickoff", 0, kn);
		chk("lamp_hold", 1, wl);
		cyc(0, 0, 0);
		n = 0;
		while (kn !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
		chk("released", 1, kn);
		repeat (30) @(posedge pclk);
		chk("lamp_off", 0, wl);
		apb(1, CMG_OFS_CTRL, 32'h0000_0011);
		arm();
		cyc(1, 0, 0);
		repeat (4) cyc(0, 0, 1);
		chk("ti_open", 1, ewl);
		cyc(0, 1, 0);
		repeat (2) cyc(0, 0, 1);
		cyc(0, 0, 0);
		chk("ti_close", 0, ewl);
		repeat (50) @(posedge pclk);
		close_out();
	end
endmodule // cmg_main_gate_test
`default_nettype wire
